// ---- adc_seq_pkg.sv ----
// Package for the acquisition sequencer: register map, field positions,
// reset values, cycle counts and the carrier structs.
// Assumes a 50 MHz system clock shared by all users of the package.
package adc_seq_pkg;

    // Clock and timing
    localparam int  CLOCK_HZ          = 50_000_000;
    localparam int  COUNT_TICK_HZ     = 10_000_000;
    localparam int  TICK_CYCLES       = CLOCK_HZ / COUNT_TICK_HZ;
    localparam int  CONV_TIME_NS      = 2000;
    localparam int  CONV_CYCLES       = (CONV_TIME_NS * (CLOCK_HZ / 1_000_000))
                                        / 1000;

    // 8-bit window offsets
    localparam logic [4:0] OFS8_SCAN_CTRL     = 5'h02;
    localparam logic [4:0] OFS8_BURST_CTRL    = 5'h03;
    localparam logic [4:0] OFS8_FIFO_STATUS   = 5'h08;
    localparam logic [4:0] OFS8_OVERSAMPLE    = 5'h1A;
    localparam logic [4:0] OFS8_TRIG_SELECT   = 5'h1B;
    localparam logic [4:0] OFS8_BOARD_RESET   = 5'h1D;
    localparam logic [4:0] OFS8_GATE_ENABLE   = 5'h1E;
    // 16-bit window offsets
    localparam logic [4:0] OFS16_FIFO_READ    = 5'h00;
    localparam logic [4:0] OFS16_GAIN_LOW     = 5'h04;
    localparam logic [4:0] OFS16_GAIN_HIGH    = 5'h06;

    // Command values
    localparam logic [7:0] BURST_ON_VALUE     = 8'h01;
    localparam logic [7:0] BURST_OFF_VALUE    = 8'h00;
    localparam logic [7:0] GATE_ENABLE_VALUE  = 8'h40;
    localparam logic [7:0] TRIG_CASCADE_VALUE = 8'h01;
    localparam logic [7:0] OVS_X1_VALUE       = 8'h11;
    localparam logic [7:0] OVS_X2_VALUE       = 8'h91;
    localparam logic [7:0] OVS_X8_VALUE       = 8'h90;
    localparam logic [7:0] OVS_X16_VALUE      = 8'h10;

    // Status bit positions
    localparam int  STAT_EMPTY_BIT    = 7;
    localparam int  STAT_FULL_BIT     = 6;
    localparam int  STAT_HALF_BIT     = 5;

    // FIFO geometry
    localparam int  FIFO_DEPTH        = 1024;
    localparam int  FIFO_AW           = 10;
    localparam int  FIFO_HALF         = FIFO_DEPTH / 2;

    // Reset values
    localparam logic [15:0] GAIN_RESET      = 16'h0000;
    localparam logic [7:0]  SCAN_RESET      = 8'h00;
    localparam logic [15:0] DIVIDER_RESET   = 16'h0002;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_BURST,
        SEQ_TIMED_WAIT,
        SEQ_TIMED_SCAN
    } seq_state_type;

    // Host register access
    typedef struct packed {
        logic        wr8;
        logic        rd8;
        logic        wr16;
        logic        rd16;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } host_req_type;

    // Converter request and answer
    typedef struct packed {
        logic       start;
        logic [3:0] channel;
        logic [1:0] gain;
    } conv_req_type;

    typedef struct packed {
        logic        done;
        logic [15:0] data;
    } conv_ans_type;

endpackage : adc_seq_pkg

// ---- interval_counter.sv ----
// One 16-bit rate-generator counter: reloads from its load value and
// pulses its output for one cycle each time it counts through.
// Assumes tick is a one-cycle count enable from the caller.
`timescale 1ns/1ps
module interval_counter
    import adc_seq_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Counting
    input  wire logic        gate,
    input  wire logic        tick,
    input  wire logic [15:0] loadValue,
    output logic             pulse
);

    typedef struct packed {
        logic [15:0] count;
        logic        pulse;
    } cnt_state_type;

    cnt_state_type state_r;
    cnt_state_type state_nxt;

    always_comb
    begin
        state_nxt       = state_r;
        state_nxt.pulse = 1'b0;
        if (!gate)
        begin
            state_nxt.count = loadValue;
        end
        else if (tick)
        begin
            // Mode 2 style: output pulses when count reaches one
            if (state_r.count <= 16'h0001)
            begin
                state_nxt.count = loadValue;
                state_nxt.pulse = 1'b1;
            end
            else
            begin
                state_nxt.count = state_r.count - 16'h0001;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign pulse = state_r.pulse;

endmodule : interval_counter

// ---- adc_acquisition_sequencer.sv ----
// Acquisition sequencer: burst and counter-timed scans with oversampling,
// a 1024-sample result FIFO and the host register windows.
// Assumes the converter repeats its done pulse until the next start and that
// host strobes are one-cycle pulses synchronous to clock.
//
// Notes on behaviour
// - Writing 1 to burst control enables burst
// - Burst samples all use one gain code
// - Empty clears with data; half at half
// - Burst converts back to back, one channel
// - Writing 0 to burst control stops burst
// - Full FIFO pauses conversions until host read
// - First counter at 10 MHz, cascaded second
// - Writing 40 pre-enables counter gates
// - Writing 01 lets counter timeouts start scans
// - Scan needs oversample write then timeout
// - Each channel sampled 1, 2, 8 or 16 times
// - FIFO holds 1024 sixteen-bit samples
// - Half-full raises interrupt when enabled
// - Empty true only with no samples
// - Data read returns and removes oldest sample
// - Board reset read stops acquisition, idles
// - Channels step start to end, then wrap
// - Burst uses start nibble only
// - Oversample codes 11, 91, 90, 10 decode
// - Status bits 7 empty, 6 full, 5 half
`timescale 1ns/1ps
module adc_acquisition_sequencer
    import adc_seq_pkg::*;
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Host register windows
    input  wire host_req_type hostReq,
    output logic [15:0]       hostRdata,
    // Converter
    output conv_req_type      convReq,
    input  wire conv_ans_type convAns,
    // Scan-rate divider loads, from the counter programming logic
    input  wire logic [15:0]  divLoadFirst,
    input  wire logic [15:0]  divLoadSecond,
    // Interrupt
    input  wire logic         halfIrqEnable,
    output logic              halfIrq
);

    typedef struct packed {
        seq_state_type state;
        logic          burstOn;
        logic          timedArmed;
        logic          gateOn;
        logic          trigOn;
        logic [7:0]    scanCtrl;
        logic [15:0]   gainLow;
        logic [15:0]   gainHigh;
        logic [3:0]    channel;
        logic [3:0]    overCount;
        logic [3:0]    overLast;
        logic          busy;
        logic [6:0]    convTimer;
        logic [2:0]    tickDiv;
        logic [FIFO_AW-1:0] wrPtr;
        logic [FIFO_AW-1:0] rdPtr;
        logic [FIFO_AW:0]   level;
        logic [15:0]   rdata;
        logic [3:0]    convChan;
        logic [1:0]    convGain;
        logic          convStart;
    } seq_reg_type;

    seq_reg_type r_r;
    seq_reg_type r_nxt;

    logic [15:0] fifoMem [FIFO_DEPTH];
    logic [15:0] fifoHead;
    logic        fifoPush;
    logic        fifoPop;
    logic        fifoFull;
    logic        fifoEmpty;
    logic        fifoHalf;
    logic        firstPulse;
    logic        scanTrigger;
    logic        tick10;

    assign fifoFull  = (r_r.level == (FIFO_AW+1)'(FIFO_DEPTH));
    assign fifoEmpty = (r_r.level == '0);
    assign fifoHalf  = (r_r.level >= (FIFO_AW+1)'(FIFO_HALF));
    assign fifoHead  = fifoMem[r_r.rdPtr];

    // Pop on a read of the data word; push on a finished conversion
    assign fifoPop   = hostReq.rd16 && hostReq.addr == OFS16_FIFO_READ
                       && !fifoEmpty;
    assign fifoPush  = convAns.done && r_r.busy && !fifoFull
                       && r_r.convTimer == '0;

    assign tick10 = (r_r.tickDiv == 3'(TICK_CYCLES - 1));

    interval_counter first_counter (
        .clock     (clock),
        .rst       (rst),
        .gate      (r_r.gateOn),
        .tick      (tick10),
        .loadValue (divLoadFirst),
        .pulse     (firstPulse)
    );

    interval_counter second_counter (
        .clock     (clock),
        .rst       (rst),
        .gate      (r_r.gateOn),
        .tick      (firstPulse),
        .loadValue (divLoadSecond),
        .pulse     (scanTrigger)
    );

    // Gain code for a channel: two bits per channel across both words
    function automatic logic [1:0] gain_of(input logic [15:0] lo,
                                           input logic [15:0] hi,
                                           input logic [3:0]  ch);
        logic [31:0] all;
        all = {hi, lo};
        return all[{ch, 1'b0} +: 2];
    endfunction : gain_of

    always_comb
    begin
        logic       canConvert;
        logic       sampleDone;
        logic [3:0] startCh;
        logic [3:0] endCh;
        canConvert = 1'b0;
        sampleDone = 1'b0;
        r_nxt      = r_r;
        startCh    = r_r.scanCtrl[3:0];
        endCh      = r_r.scanCtrl[7:4];
        r_nxt.convStart = 1'b0;
        r_nxt.tickDiv   = tick10 ? 3'h0 : r_r.tickDiv + 3'h1;

        // Host writes to the 8-bit window
        if (hostReq.wr8)
        begin
            case (hostReq.addr)
                OFS8_SCAN_CTRL:
                begin
                    r_nxt.scanCtrl = hostReq.wdata[7:0];
                    r_nxt.channel  = hostReq.wdata[3:0];
                end
                OFS8_BURST_CTRL:
                begin
                    if (hostReq.wdata[7:0] == BURST_ON_VALUE)
                    begin
                        r_nxt.burstOn = 1'b1;
                    end
                    else if (hostReq.wdata[7:0] == BURST_OFF_VALUE)
                    begin
                        r_nxt.burstOn = 1'b0;
                    end
                end
                OFS8_GATE_ENABLE:
                    r_nxt.gateOn = (hostReq.wdata[7:0] == GATE_ENABLE_VALUE);
                OFS8_TRIG_SELECT:
                    r_nxt.trigOn = (hostReq.wdata[7:0] == TRIG_CASCADE_VALUE);
                OFS8_OVERSAMPLE:
                begin
                    r_nxt.timedArmed = 1'b1;
                    case (hostReq.wdata[7:0])
                        OVS_X1_VALUE:  r_nxt.overLast = 4'd0;
                        OVS_X2_VALUE:  r_nxt.overLast = 4'd1;
                        OVS_X8_VALUE:  r_nxt.overLast = 4'd7;
                        OVS_X16_VALUE: r_nxt.overLast = 4'd15;
                        default:       r_nxt.timedArmed = 1'b0;
                    endcase
                end
                default:
                begin
                end
            endcase
        end

        if (hostReq.wr16 && hostReq.addr == OFS16_GAIN_LOW)
        begin
            r_nxt.gainLow = hostReq.wdata;
        end
        if (hostReq.wr16 && hostReq.addr == OFS16_GAIN_HIGH)
        begin
            r_nxt.gainHigh = hostReq.wdata;
        end

        // Read data word is registered the cycle the read is taken
        if (hostReq.rd16 && hostReq.addr == OFS16_FIFO_READ)
        begin
            r_nxt.rdata = fifoEmpty ? 16'h0000 : fifoHead;
        end
        else if (hostReq.rd8 && hostReq.addr == OFS8_FIFO_STATUS)
        begin
            r_nxt.rdata = '0;
            r_nxt.rdata[STAT_EMPTY_BIT] = fifoEmpty;
            r_nxt.rdata[STAT_FULL_BIT]  = fifoFull;
            r_nxt.rdata[STAT_HALF_BIT]  = fifoHalf;
        end
        else if (hostReq.rd8 || hostReq.rd16)
        begin
            r_nxt.rdata = '0;
        end

        // Conversion timing; one converter slot at a time
        if (r_r.busy)
        begin
            if (r_r.convTimer != '0)
            begin
                r_nxt.convTimer = r_r.convTimer - 7'h01;
            end
            if (convAns.done && r_r.convTimer == '0 && !fifoFull)
            begin
                r_nxt.busy = 1'b0;
                sampleDone = 1'b1;
            end
        end
        // A full FIFO holds the result and any new start
        canConvert = !r_r.busy && !fifoFull;

        case (r_r.state)
            SEQ_IDLE:
            begin
                if (r_r.burstOn)
                begin
                    r_nxt.state = SEQ_BURST;
                end
                else if (r_r.timedArmed && r_r.trigOn && r_r.gateOn)
                begin
                    r_nxt.state = SEQ_TIMED_WAIT;
                end
            end
            SEQ_BURST:
            begin
                if (!r_r.burstOn)
                begin
                    r_nxt.state = SEQ_IDLE;
                end
                else if (canConvert)
                begin
                    // Back to back on the start channel only
                    r_nxt.convStart = 1'b1;
                    r_nxt.convChan  = startCh;
                    r_nxt.convGain  = gain_of(r_r.gainLow, r_r.gainHigh,
                                              startCh);
                    r_nxt.busy      = 1'b1;
                    r_nxt.convTimer = 7'(CONV_CYCLES - 1);
                end
            end
            SEQ_TIMED_WAIT:
            begin
                if (!(r_r.timedArmed && r_r.trigOn && r_r.gateOn))
                begin
                    r_nxt.state = SEQ_IDLE;
                end
                else if (scanTrigger)
                begin
                    r_nxt.state     = SEQ_TIMED_SCAN;
                    r_nxt.channel   = startCh;
                    r_nxt.overCount = 4'd0;
                end
            end
            SEQ_TIMED_SCAN:
            begin
                if (sampleDone)
                begin
                    if (r_r.overCount != r_r.overLast)
                    begin
                        r_nxt.overCount = r_r.overCount + 4'd1;
                    end
                    else
                    begin
                        r_nxt.overCount = 4'd0;
                        if (r_r.channel >= endCh)
                        begin
                            // Scan over; channel wraps to the start
                            r_nxt.channel = startCh;
                            r_nxt.state   = SEQ_TIMED_WAIT;
                        end
                        else
                        begin
                            r_nxt.channel = r_r.channel + 4'd1;
                        end
                    end
                end
                else if (canConvert)
                begin
                    r_nxt.convStart = 1'b1;
                    r_nxt.convChan  = r_r.channel;
                    r_nxt.convGain  = gain_of(r_r.gainLow, r_r.gainHigh,
                                              r_r.channel);
                    r_nxt.busy      = 1'b1;
                    r_nxt.convTimer = 7'(CONV_CYCLES - 1);
                end
            end
            default:
                r_nxt.state = SEQ_IDLE;
        endcase

        // FIFO pointers and level
        if (fifoPush)
        begin
            r_nxt.wrPtr = r_r.wrPtr + 1'b1;
        end
        if (fifoPop)
        begin
            r_nxt.rdPtr = r_r.rdPtr + 1'b1;
        end
        case ({fifoPush, fifoPop})
            2'b10:   r_nxt.level = r_r.level + 1'b1;
            2'b01:   r_nxt.level = r_r.level - 1'b1;
            default: r_nxt.level = r_r.level;
        endcase

        // Board reset read: stop everything and return to idle
        if (hostReq.rd8 && hostReq.addr == OFS8_BOARD_RESET)
        begin
            r_nxt.state      = SEQ_IDLE;
            r_nxt.burstOn    = 1'b0;
            r_nxt.timedArmed = 1'b0;
            r_nxt.gateOn     = 1'b0;
            r_nxt.trigOn     = 1'b0;
            r_nxt.busy       = 1'b0;
            r_nxt.convStart  = 1'b0;
            r_nxt.overCount  = 4'd0;
            r_nxt.rdata      = '0;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            r_r          <= '0;
            r_r.state    <= SEQ_IDLE;
            r_r.scanCtrl <= SCAN_RESET;
            r_r.gainLow  <= GAIN_RESET;
            r_r.gainHigh <= GAIN_RESET;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // Sample storage has no reset; pointers define what is valid
    always_ff @(posedge clock)
    begin
        if (fifoPush)
        begin
            fifoMem[r_r.wrPtr] <= convAns.data;
        end
    end

    assign hostRdata       = r_r.rdata;
    assign convReq.start   = r_r.convStart;
    assign convReq.channel = r_r.convChan;
    assign convReq.gain    = r_r.convGain;
    assign halfIrq         = halfIrqEnable && fifoHalf;

endmodule : adc_acquisition_sequencer

// ---- adc_seq_properties.sv ----
// Port checker for the acquisition sequencer.
// Assumes it is bound to the sequencer top and sees only its ports.
`timescale 1ns/1ps
module adc_seq_properties
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic         clock,
    input wire logic         rst,
    // Host and converter sides
    input wire host_req_type hostReq,
    input wire logic [15:0]  hostRdata,
    input wire conv_req_type convReq,
    input wire conv_ans_type convAns,
    // Divider loads and interrupt
    input wire logic [15:0]  divLoadFirst,
    input wire logic [15:0]  divLoadSecond,
    input wire logic         halfIrqEnable,
    input wire logic         halfIrq
);
    logic [31:0] gain_r;
    logic [3:0]  first_r;
    logic        burst_r;
    logic        armed_r;
    logic        quiet_r;
    logic        rdPrev_r;
    logic [7:0]  gap_r;
    logic        wrBurst;
    logic        wrArm;
    logic        stopRd;
    logic        wr16;
    assign wrBurst = hostReq.wr8 && hostReq.addr == OFS8_BURST_CTRL;
    assign wrArm   = hostReq.wr8 && hostReq.addr == OFS8_OVERSAMPLE;
    assign stopRd  = hostReq.rd8 && hostReq.addr == OFS8_BOARD_RESET;
    assign wr16    = hostReq.wr16;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            gain_r   <= 32'h0000_0000;
            first_r  <= 4'h0;
            burst_r  <= 1'b0;
            armed_r  <= 1'b0;
            quiet_r  <= 1'b1;
            rdPrev_r <= 1'b0;
            gap_r    <= 8'hFF;
        end
        else
        begin
            if (wr16 && hostReq.addr == OFS16_GAIN_LOW)
                gain_r[15:0] <= hostReq.wdata;
            if (wr16 && hostReq.addr == OFS16_GAIN_HIGH)
                gain_r[31:16] <= hostReq.wdata;
            if (hostReq.wr8 && hostReq.addr == OFS8_SCAN_CTRL)
                first_r <= hostReq.wdata[3:0];
            burst_r  <= !stopRd && (wrBurst
                        ? hostReq.wdata[7:0] == BURST_ON_VALUE : burst_r);
            armed_r  <= !stopRd && (armed_r || wrArm);
            // A stop read, or burst off with no timed run armed, is quiet
            quiet_r  <= stopRd || (quiet_r && !wrBurst && !wrArm)
                        || (wrBurst && !armed_r
                            && hostReq.wdata[7:0] == BURST_OFF_VALUE);
            rdPrev_r <= hostReq.rd8 || hostReq.rd16;
            gap_r    <= convReq.start ? 8'h00
                        : gap_r + {7'h00, gap_r != 8'hFF};
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    irq_gate_a: assert property (!halfIrqEnable |-> !halfIrq)
        else $error("half interrupt raised while disabled");
    start_gap_a: assert property (convReq.start |-> gap_r >= 8'h61)
        else $error("conversion started too soon after the last");
    req_hold_a: assert property (!convReq.start |->
        $stable(convReq.channel) && $stable(convReq.gain))
        else $error("channel or gain moved without a start");
    quiet_stop_a: assert property (quiet_r && $past(quiet_r) |->
        !convReq.start)
        else $error("conversion started after a stop");
    burst_chan_a: assert property (burst_r && !armed_r && convReq.start
        |-> convReq.channel == first_r)
        else $error("burst converted a channel other than the first");
    gain_pick_a: assert property (convReq.start |->
        convReq.gain == gain_r[{convReq.channel, 1'b0} +: 2])
        else $error("gain code does not match the channel");
    arm_wait_a: assert property (wrArm && !burst_r |=>
        !convReq.start [*8])
        else $error("timed scan began before the counters ran out");
    rdata_hold_a: assert property (!rdPrev_r |-> $stable(hostRdata))
        else $error("read data changed without a read");

    burst_seen_c: cover property (burst_r && convReq.start);
    timed_seen_c: cover property (armed_r && convReq.start);
    half_seen_c: cover property (halfIrq);
endmodule : adc_seq_properties

// ---- adc_converter_model.sv ----
// Converter model: answers each start with a done pulse carrying
// {channel, gain, serial}. Assumes one outstanding start at a time.
`timescale 1ns/1ps
module adc_converter_model
    import adc_seq_pkg::*;
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Converter side of the sequencer
    input  wire conv_req_type convReq,
    output conv_ans_type      convAns
);
    logic [7:0]  wait_r;
    logic [9:0]  serial_r;
    logic        pending_r;
    logic [15:0] sample_r;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wait_r    <= 8'h00;
            serial_r  <= 10'h000;
            pending_r <= 1'b0;
            sample_r  <= 16'h0000;
            convAns   <= '0;
        end
        else
        begin
            convAns.done <= 1'b0;
            // Data lines do not hold between results
            convAns.data <= ~convAns.data;
            if (convReq.start)
            begin
                pending_r <= 1'b1;
                // Alternate prompt and slow answers
                wait_r    <= serial_r[0] ? 8'h6D : 8'h63;
                sample_r  <= {convReq.channel, convReq.gain, serial_r};
                serial_r  <= serial_r + 10'h001;
            end
            else if (wait_r != 8'h00)
                wait_r <= wait_r - 8'h01;
            else if (pending_r)
            begin
                convAns <= {1'b1, sample_r};
                // Offered again until the next start: a full FIFO holds it off
                wait_r  <= 8'h77;
            end
        end
    end
endmodule : adc_converter_model

// ---- tb_adc_acquisition_sequencer.sv ----
// Testbench for the acquisition sequencer: burst, half flag, drain and
// all four timed oversample codes. Assumes the converter model file.
`timescale 1ns/1ps
module tb_adc_acquisition_sequencer import adc_seq_pkg::*;;
    logic         clock = 1'b0;
    logic         rst = 1'b1;
    host_req_type hostReq = '0;
    logic [15:0]  hostRdata;
    conv_req_type convReq;
    conv_ans_type convAns;
    // Rate 12.5 kHz: 40 * 20 = 10e6 / 12500, longer than any scan here
    logic [15:0]  divLoadFirst = 16'h0028;
    logic [15:0]  divLoadSecond = 16'h0014;
    logic         halfIrqEnable = 1'b1;
    logic         halfIrq;
    int           nErrors = 0;
    int           checks = 0;
    int           seed = 32'h0000_A676;
    logic [31:0]  gainWord;
    logic [9:0]   expSerial;
    logic [15:0]  lastRead;
    logic [31:0]  expQ[$];
    logic [31:0]  note;
    logic         readTaken = 1'b0;
    logic [7:0]   codes[4] = '{OVS_X1_VALUE, OVS_X2_VALUE, OVS_X8_VALUE,
                               OVS_X16_VALUE};
    int           reps[4] = '{1, 2, 8, 16};
    int           n;

    adc_acquisition_sequencer u_adc_acquisition_sequencer (.clock(clock),
        .rst(rst), .hostReq(hostReq), .hostRdata(hostRdata),
        .convReq(convReq), .convAns(convAns), .divLoadFirst(divLoadFirst),
        .divLoadSecond(divLoadSecond), .halfIrqEnable(halfIrqEnable),
        .halfIrq(halfIrq));
    adc_converter_model u_adc_converter_model (.clock(clock), .rst(rst),
        .convReq(convReq), .convAns(convAns));

    always #10 clock = ~clock;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            nErrors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check

    // One strobe cycle; reads note {mask, expected}, mask 0 means a poll
    task automatic bus(input logic wr, input logic wide, input logic [4:0] a,
                       input logic [15:0] d, input logic [15:0] mask);
        @(negedge clock);
        if (!wr)
            expQ.push_back({mask, d & mask});
        hostReq.addr = a;
        hostReq.wdata = d;
        hostReq.wr8 = wr & !wide;
        hostReq.wr16 = wr & wide;
        hostReq.rd8 = !wr & !wide;
        hostReq.rd16 = !wr & wide;
        @(negedge clock);
        hostReq = '0;
        lastRead = hostRdata;
    endtask : bus

    task automatic waitData;
        int k;
        k = 0;
        do
        begin
            bus(1'b0, 1'b0, OFS8_FIFO_STATUS, 16'h0000, 16'h0000);
            k++;
        end
        while (lastRead[STAT_EMPTY_BIT] && k < 5000);
        if (lastRead[STAT_EMPTY_BIT])
            check(lastRead & 16'h0080, 16'h0000);
    endtask : waitData

    task automatic endOfTest;
        $display("checks %0d mismatches %0d", checks, nErrors);
        if (nErrors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : endOfTest

    always @(posedge clock)
        readTaken <= hostReq.rd8 | hostReq.rd16;

    always @(negedge clock)
    begin
        if (readTaken)
        begin
            note = expQ.pop_front();
            if (note[31:16] != 16'h0000)
                check(hostRdata & note[31:16], note[15:0]);
        end
    end

    initial
    begin
        repeat (3) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        bus(1'b0, 1'b0, OFS8_FIFO_STATUS, 16'h0080, 16'h00E0);
        bus(1'b0, 1'b1, OFS16_FIFO_READ, 16'h0000, 16'hFFFF);
        $display("test reset done");
        gainWord = $random(seed);
        // End nibble below the start nibble must not matter in burst
        bus(1'b1, 1'b0, OFS8_SCAN_CTRL, 16'h0035, 16'h0000);
        bus(1'b1, 1'b1, OFS16_GAIN_LOW, gainWord[15:0], 16'h0000);
        bus(1'b1, 1'b0, OFS8_BURST_CTRL, 16'h0001, 16'h0000);
        for (n = 0; n < 60000 && halfIrq !== 1'b1; n++)
            @(negedge clock);
        bus(1'b0, 1'b0, OFS8_FIFO_STATUS, 16'h0020, 16'h00E0);
        halfIrqEnable = 1'b0;
        @(negedge clock);
        check({15'h0000, halfIrq}, 16'h0000);
        halfIrqEnable = 1'b1;
        bus(1'b1, 1'b0, OFS8_BURST_CTRL, 16'h0000, 16'h0000);
        repeat (300) @(negedge clock);
        expSerial = 10'h000;
        do
        begin
            bus(1'b0, 1'b1, OFS16_FIFO_READ,
                {4'h5, gainWord[11:10], expSerial}, 16'hFFFF);
            expSerial++;
            bus(1'b0, 1'b0, OFS8_FIFO_STATUS, 16'h0000, 16'h0000);
        end
        while (!lastRead[STAT_EMPTY_BIT] && expSerial != 10'h000);
        check({15'h0000, expSerial >= 10'h200}, 16'h0001);
        bus(1'b0, 1'b0, OFS8_FIFO_STATUS, 16'h0080, 16'h00E0);
        $display("test burst done");
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b0, 1'b0, OFS8_BOARD_RESET, 16'h0000, 16'h0000);
            gainWord = $random(seed);
            bus(1'b1, 1'b0, OFS8_SCAN_CTRL, 16'h0021, 16'h0000);
            bus(1'b1, 1'b1, OFS16_GAIN_LOW, gainWord[15:0], 16'h0000);
            bus(1'b1, 1'b0, OFS8_GATE_ENABLE, 16'h0040, 16'h0000);
            bus(1'b1, 1'b0, OFS8_TRIG_SELECT, 16'h0001, 16'h0000);
            expSerial = u_adc_converter_model.serial_r;
            bus(1'b1, 1'b0, OFS8_OVERSAMPLE, {8'h00, codes[c]},
                16'h0000);
            for (int ch = 1; ch <= 2; ch++)
                repeat (reps[c])
                begin
                    waitData();
                    bus(1'b0, 1'b1, OFS16_FIFO_READ,
                        {ch[3:0], gainWord[2 * ch +: 2], expSerial}, 16'hFFFF);
                    expSerial++;
                end
            $display("test timed code %h done", codes[c]);
        end
        bus(1'b0, 1'b0, OFS8_BOARD_RESET, 16'h0000, 16'h0000);
        repeat (5000) @(negedge clock);
        bus(1'b0, 1'b0, OFS8_FIFO_STATUS, 16'h0080, 16'h00E0);
        $display("test stop done");
        endOfTest();
    end

    initial
    begin
        repeat (100000) @(posedge clock);
        nErrors++;
        $display("unexpected timeout at %0t", $time);
        endOfTest();
    end
endmodule : tb_adc_acquisition_sequencer

bind adc_acquisition_sequencer adc_seq_properties u_adc_seq_properties (
    .clock(clock), .rst(rst), .hostReq(hostReq), .hostRdata(hostRdata),
    .convReq(convReq), .convAns(convAns), .divLoadFirst(divLoadFirst),
    .divLoadSecond(divLoadSecond), .halfIrqEnable(halfIrqEnable),
    .halfIrq(halfIrq));
